// >>> pkg/tsm_defs.vh
`ifndef TSM_DEFS_VH
`define TSM_DEFS_VH

// System clock
`define TSM_CLK_MHZ          25

// Register byte offsets
`define TSM_ADDR_W           8
`define TSM_REG_STATUS       8'h00
`define TSM_REG_MASK         8'h04
`define TSM_REG_CLKSTAT      8'h08
`define TSM_REG_CHAN_BASE    8'h80

// Channel configuration fields
`define TSM_CF_FMT_LO        0
`define TSM_CF_FMT_HI        1
`define TSM_CF_INV           3
`define TSM_CF_ES            4
`define TSM_CF_SEL_LO        5
`define TSM_CF_SEL_HI        7
`define TSM_CF_CLKOK         8
`define TSM_CFG_RST          8'h00

// Interface formats
`define TSM_FMT_SR_NRZ       2'h0
`define TSM_FMT_DR_NRZ       2'h1
`define TSM_FMT_DR_RZ        2'h2

// Indication select codes
`define TSM_SEL_PATTERN      3'h0
`define TSM_SEL_AIS          3'h1
`define TSM_SEL_TOC          3'h2
`define TSM_SEL_TX_LOSS_OF_SIGNAL         3'h3
`define TSM_SEL_EXZ          3'h4
`define TSM_SEL_BPV          3'h5
`define TSM_SEL_EXZ_BPV      3'h6
`define TSM_SEL_RLOS         3'h7

// Interrupt status bits
`define TSM_EV_MCLK_MISS     0
`define TSM_EV_BAD_CODE      1
`define TSM_EV_TCLK_LOST     2
`define TSM_EV_W             3

// Timing
`define TSM_TCLK_LOSS_NS     2000
`define TSM_TCLK_LOSS_CYC    ((`TSM_TCLK_LOSS_NS * `TSM_CLK_MHZ) / 1000)
`define TSM_MCLK_BASE_KHZ    1544
`define TSM_MCLK_PER_CYC(m)  ((`TSM_CLK_MHZ * 1000) / (`TSM_MCLK_BASE_KHZ * (m)))
`define TSM_MCLK_MAX_CODE    4'h3
`define TSM_RST_HOLD_CYC     5'h10

`endif

// >>> logic/tsm_sync.v
`timescale 1ns/10ps
module tsm_sync
#(
    parameter W = 1
)
(
    // Clock and reset
    input  wire         clk,
    input  wire         rstn,
    // Asynchronous in, synchronous out
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] stage1;
    reg [W-1:0] stage2;

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stage1 <= {W{1'b0}};
            stage2 <= {W{1'b0}};
        end
        else
        begin
            stage1 <= d;
            stage2 <= stage1;
        end
    end

    assign q = stage2;
endmodule

// >>> logic/tsm_mclk_mon.v
`timescale 1ns/10ps
`include "tsm_defs.vh"
module tsm_mclk_mon
(
    // Clock and reset
    input  wire       clk,
    input  wire       rstn,
    // Synchronised master clock pin and frequency code
    input  wire       mclk_s,
    input  wire [3:0] code_s,
    // Status
    output reg        mclk_missing,
    output reg        bad_code,
    output wire       auto_rst
);
    reg       mclk_prev;
    reg [5:0] phase_cnt;
    reg [4:0] hold_cnt;

    // One full master clock period in system cycles for the given code
    function [5:0] period_of;
        input [3:0] code;
        integer     v;
        begin
            case (code[1:0])
                2'h0:    v = `TSM_MCLK_PER_CYC(1);
                2'h1:    v = `TSM_MCLK_PER_CYC(2);
                2'h2:    v = `TSM_MCLK_PER_CYC(3);
                default: v = `TSM_MCLK_PER_CYC(4);
            endcase
            period_of = v[5:0];
        end
    endfunction

    wire       mclk_edge = mclk_s ^ mclk_prev;
    wire [5:0] limit     = period_of(code_s);

    // A phase held longer than a whole period means the duty cycle collapsed
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mclk_prev    <= 1'b0;
            phase_cnt    <= 6'h00;
            mclk_missing <= 1'b0;
            bad_code     <= 1'b0;
            hold_cnt     <= 5'h00;
        end
        else
        begin
            mclk_prev    <= mclk_s;
            bad_code     <= (code_s > `TSM_MCLK_MAX_CODE);
            if (mclk_edge)
                phase_cnt <= 6'h00;
            else if (phase_cnt != 6'h3F)
                phase_cnt <= phase_cnt + 6'h01;
            mclk_missing <= !mclk_edge && (phase_cnt >= limit);
            if (mclk_missing)
                hold_cnt <= `TSM_RST_HOLD_CYC;
            else if (hold_cnt != 5'h00)
                hold_cnt <= hold_cnt - 5'h01;
        end
    end

    // Reset stays asserted a while after the clock returns
    assign auto_rst = mclk_missing || (hold_cnt != 5'h00);
endmodule

// >>> logic/tsm_top.v
// Behaviour
// - Dual rail NRZ: shared indication pin is negative-rail input, sampled with positive.
// - Single rail NRZ or dual rail RZ: shared pin drives the indication output.
// - Three-bit select picks one of eight status sources for the indication.
// - Indication updates on the active transmit clock edge when that clock exists.
// - Indication output is always active high, never inverted.
// - NRZ formats: clock/negative-data pin is the transmit clock input.
// - NRZ data sampled on active clock edge; system keeps it stable there.
// - Edge-select bit picks rising or falling edge for sampling and indication.
// - Dual rail RZ: clock pin is negative-rail data, no transmit clock expected.
// - Invert bit makes both rail data inputs active low.
// - Four strap inputs give master clock as 1.544 MHz times one to four.
// - Missing master clock, by collapsed duty cycle, triggers automatic reset.
// - RZ: pos1/neg0 positive pulse, pos0/neg1 negative pulse, equal gives space.
// - Single rail NRZ: unencoded data sampled on the active transmit clock edge.
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "tsm_defs.vh"
module tsm_top
#(
    parameter NCH = 29
)
(
    // Clock and reset
    input  wire                   clk,
    input  wire                   rstn,
    // Avalon-MM slave
    input  wire [`TSM_ADDR_W-1:0] avs_address,
    input  wire                   avs_read,
    input  wire                   avs_write,
    input  wire [31:0]            avs_writedata,
    input  wire [3:0]             avs_byteenable,
    output reg  [31:0]            avs_readdata,
    output wire                   avs_waitrequest,
    // Interrupt
    output wire                   irq,
    // Master clock pins
    input  wire                   master_clock_in,
    input  wire [3:0]             master_clock_freq_code,
    // Transmit system pins, per channel
    input  wire [NCH-1:0]         tx_single_rail_data,
    input  wire [NCH-1:0]         tx_system_clock,
    input  wire [NCH-1:0]         tx_negative_rail_data,
    output wire [NCH-1:0]         tx_indication_out,
    output wire [NCH-1:0]         tx_indication_oe,
    // Status sources, same clock
    input  wire [NCH-1:0]         pattern_generator_status,
    input  wire [NCH-1:0]         alarm_indication_detect,
    input  wire [NCH-1:0]         tx_overcurrent,
    input  wire [NCH-1:0]         tx_loss_of_signal,
    input  wire [NCH-1:0]         excess_zero_detect,
    input  wire [NCH-1:0]         bipolar_violation_detect,
    input  wire [NCH-1:0]         rx_loss_of_signal,
    // Towards the line driver
    output wire [NCH-1:0]         line_out_tip,
    output wire [NCH-1:0]         line_out_ring,
    output wire [NCH-1:0]         tx_data_strobe,
    // Device status
    output wire                   master_clock_missing,
    output wire                   auto_reset
);
    localparam integer LOSS_CYC = `TSM_TCLK_LOSS_CYC;
    localparam [7:0]   LOSS_LIM = LOSS_CYC[7:0];

    // Bus handshake: one wait state, access completes on the second edge
    reg                    ack;
    wire                   req  = avs_read | avs_write;
    wire                   fire = req & ack;
    assign avs_waitrequest = req & ~ack;

    reg  [`TSM_EV_W-1:0]   status;
    reg  [`TSM_EV_W-1:0]   mask;
    wire [`TSM_EV_W-1:0]   events;
    wire [8*NCH-1:0]       cfg_all;
    wire [NCH-1:0]         clk_ok_all;
    wire [NCH-1:0]         lost_all;
    reg  [31:0]            rd_mux;
    integer                i;

    // Synchronised pins
    wire [NCH-1:0]         sd_s;
    wire [NCH-1:0]         ck_s;
    wire [NCH-1:0]         ng_s;
    wire                   mclk_s;
    wire [3:0]             code_s;
    wire                   bad_code;

    function chan_hit;
        input [`TSM_ADDR_W-1:0] a;
        input integer           idx;
        begin
            chan_hit = a[7] && (a[1:0] == 2'h0) && ({27'h0, a[6:2]} == idx);
        end
    endfunction

    // Source order follows the select codes
    function ind_pick;
        input [2:0] sel;
        input [7:0] src;
        begin
            ind_pick = src[sel];
        end
    endfunction

    tsm_sync #(.W(3*NCH)) u_pin_sync
    (
        .clk  (clk),
        .rstn (rstn),
        .d    ({tx_negative_rail_data, tx_system_clock, tx_single_rail_data}),
        .q    ({ng_s, ck_s, sd_s})
    );

    tsm_sync #(.W(5)) u_mclk_sync
    (
        .clk  (clk),
        .rstn (rstn),
        .d    ({master_clock_freq_code, master_clock_in}),
        .q    ({code_s, mclk_s})
    );

    tsm_mclk_mon u_mclk_mon
    (
        .clk          (clk),
        .rstn         (rstn),
        .mclk_s       (mclk_s),
        .code_s       (code_s),
        .mclk_missing (master_clock_missing),
        .bad_code     (bad_code),
        .auto_rst     (auto_reset)
    );

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1)
        begin : g_ch
            reg  [7:0] cfg;
            reg        clk_prev;
            reg        tip;
            reg        ring;
            reg        strobe;
            reg        ind;
            reg        clk_ok;
            reg  [7:0] loss_cnt;

            wire [1:0] fmt     = cfg[`TSM_CF_FMT_HI:`TSM_CF_FMT_LO];
            wire       inv     = cfg[`TSM_CF_INV];
            wire       es      = cfg[`TSM_CF_ES];
            wire [2:0] sel     = cfg[`TSM_CF_SEL_HI:`TSM_CF_SEL_LO];
            wire       has_clk = (fmt != `TSM_FMT_DR_RZ);
            wire       rise    = ck_s[g] & ~clk_prev;
            wire       fall    = ~ck_s[g] & clk_prev;
            wire       act     = es ? fall : rise;
            // RZ format reads the clock pin as the negative rail
            wire       pos     = sd_s[g] ^ inv;
            wire       neg     = (has_clk ? ng_s[g] : ck_s[g]) ^ inv;
            wire [7:0] src     = {rx_loss_of_signal[g],
                                  excess_zero_detect[g] | bipolar_violation_detect[g],
                                  bipolar_violation_detect[g],
                                  excess_zero_detect[g],
                                  tx_loss_of_signal[g],
                                  tx_overcurrent[g],
                                  alarm_indication_detect[g],
                                  pattern_generator_status[g]};
            wire       wr_ch   = fire && avs_write && avs_byteenable[0]
                                 && chan_hit(avs_address, g);

            always @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                    cfg <= `TSM_CFG_RST;
                else if (wr_ch)
                    cfg <= avs_writedata[7:0];
            end

            // Datapath; the master clock monitor clears it, not the setup
            always @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    clk_prev <= 1'b0;
                    tip      <= 1'b0;
                    ring     <= 1'b0;
                    strobe   <= 1'b0;
                    ind      <= 1'b0;
                    clk_ok   <= 1'b0;
                    loss_cnt <= 8'h00;
                end
                else if (auto_reset)
                begin
                    clk_prev <= 1'b0;
                    tip      <= 1'b0;
                    ring     <= 1'b0;
                    strobe   <= 1'b0;
                    ind      <= 1'b0;
                    clk_ok   <= 1'b0;
                    loss_cnt <= 8'h00;
                end
                else
                begin
                    clk_prev <= ck_s[g];
                    strobe   <= 1'b0;
                    if (has_clk)
                    begin
                        if (act)
                        begin
                            strobe   <= 1'b1;
                            tip      <= pos;
                            ring     <= (fmt == `TSM_FMT_DR_NRZ) ? neg : 1'b0;
                            ind      <= ind_pick(sel, src);
                            clk_ok   <= 1'b1;
                            loss_cnt <= 8'h00;
                        end
                        else if (loss_cnt >= LOSS_LIM)
                            clk_ok <= 1'b0;
                        else
                            loss_cnt <= loss_cnt + 8'h01;
                    end
                    else
                    begin
                        // Mark when rails differ, space when equal
                        tip      <= pos & ~neg;
                        ring     <= neg & ~pos;
                        strobe   <= pos ^ neg;
                        ind      <= ind_pick(sel, src);
                        clk_ok   <= 1'b0;
                        loss_cnt <= 8'h00;
                    end
                end
            end

            assign cfg_all[8*g +: 8]   = cfg;
            assign clk_ok_all[g]       = clk_ok;
            assign lost_all[g]         = has_clk && clk_ok && !act && (loss_cnt >= LOSS_LIM);
            assign line_out_tip[g]     = tip;
            assign line_out_ring[g]    = ring;
            assign tx_data_strobe[g]   = strobe;
            assign tx_indication_out[g] = ind;
            assign tx_indication_oe[g] = (fmt != `TSM_FMT_DR_NRZ);
        end
    endgenerate

    // Read decode
    always @*
    begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            `TSM_REG_STATUS:  rd_mux = {{(32-`TSM_EV_W){1'b0}}, status};
            `TSM_REG_MASK:    rd_mux = {{(32-`TSM_EV_W){1'b0}}, mask};
            `TSM_REG_CLKSTAT: rd_mux = {26'h0, bad_code, master_clock_missing, code_s};
            default:          rd_mux = 32'h0000_0000;
        endcase
        for (i = 0; i < NCH; i = i + 1)
        begin
            if (chan_hit(avs_address, i))
                rd_mux = {23'h0, clk_ok_all[i], cfg_all[8*i +: 8]};
        end
    end

    assign events[`TSM_EV_MCLK_MISS] = master_clock_missing;
    assign events[`TSM_EV_BAD_CODE]  = bad_code;
    assign events[`TSM_EV_TCLK_LOST] = |lost_all;

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack          <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            status       <= {`TSM_EV_W{1'b0}};
            mask         <= {`TSM_EV_W{1'b0}};
        end
        else
        begin
            ack <= req & ~ack;
            if (avs_read && !ack)
                avs_readdata <= rd_mux;
            // A new event wins over a write-one clear in the same cycle
            if (fire && avs_write && avs_byteenable[0] && avs_address == `TSM_REG_STATUS)
                status <= (status & ~avs_writedata[`TSM_EV_W-1:0]) | events;
            else
                status <= status | events;
            if (fire && avs_write && avs_byteenable[0] && avs_address == `TSM_REG_MASK)
                mask <= avs_writedata[`TSM_EV_W-1:0];
        end
    end

    assign irq = |(status & mask);
endmodule

// >>> sim/tsm_props.sv
`timescale 1ns/10ps
module tsm_props
#(
    parameter NCH = 29
)
(
    // Clock and reset
    input wire           clk,
    input wire           rstn,
    // Bus handshake
    input wire           avs_read,
    input wire           avs_write,
    input wire           avs_waitrequest,
    // Channel pins
    input wire [NCH-1:0] tx_system_clock,
    input wire [NCH-1:0] tx_indication_oe,
    input wire [NCH-1:0] tx_data_strobe,
    input wire [NCH-1:0] line_out_tip,
    // Device status
    input wire           master_clock_missing,
    input wire           auto_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_req;
        avs_read || avs_write;
    endsequence
    // Hold must outlast the missing flag by several cycles
    sequence s_hold;
        auto_reset [*8];
    endsequence
    a_wait_one: assert property (s_req ##0 avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer after one wait state");
    a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("wait state without request");
    a_oe_cfg: assert property ($changed(tx_indication_oe) |-> $past(avs_write))
        else $error("pin direction moved without a write");
    a_dr_edge: assert property (tx_data_strobe[0] && !tx_indication_oe[0] |->
        $past(tx_system_clock[0], 3) != $past(tx_system_clock[0], 4))
        else $error("sample without a clock edge");
    a_strobe_one: assert property (tx_data_strobe[0] && !tx_indication_oe[0] |=>
        !tx_data_strobe[0])
        else $error("sample strobe longer than one cycle");
    a_miss_reset: assert property (master_clock_missing |-> auto_reset ##1 (tx_data_strobe == 0))
        else $error("missing clock without reset");
    a_reset_hold: assert property ($fell(master_clock_missing) |-> s_hold)
        else $error("reset released too early");
    a_clear_path: assert property ($past(auto_reset) && auto_reset |->
        tx_data_strobe == 0 && line_out_tip == 0)
        else $error("datapath active during reset");
endmodule

bind tsm_top tsm_props #(.NCH(NCH)) tsm_props_i
(
    .clk(clk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .tx_system_clock(tx_system_clock),
    .tx_indication_oe(tx_indication_oe), .tx_data_strobe(tx_data_strobe),
    .line_out_tip(line_out_tip), .master_clock_missing(master_clock_missing),
    .auto_reset(auto_reset)
);

// >>> sim/tsm_framer.sv
`timescale 1ns/10ps
module tsm_framer
#(
    parameter NCH = 2
)
(
    // Control from the bench
    input  wire logic           run,
    input  wire logic           rz,
    input  wire logic           mclk_run,
    input  wire logic [3:0]     code,
    input  wire logic [NCH-1:0] pos,
    input  wire logic [NCH-1:0] neg,
    // Pins towards the device
    output logic                mclk,
    output logic [NCH-1:0]      tclk,
    output logic [NCH-1:0]      tdat,
    output logic [NCH-1:0]      tneg
);
    int unsigned    t = 0;
    logic [NCH-1:0] dp = 0;
    logic [NCH-1:0] dn = 0;
    initial mclk = 0;
    always #(324.0 / (code[1:0] + 1)) mclk = mclk_run ? ~mclk : mclk;
    // Rise on t%4==2, fall on t%4==0; data flips halfway between edges
    always #80
    begin
        t = (run || t[1]) ? t + 1 : 0;
        if (t % 4 == 1)
        begin
            dp = pos;
            dn = neg;
        end
        else if (t % 4 == 3 || t == 0)
        begin
            dp = ~pos;
            dn = ~neg;
        end
    end
    // Clock idles low outside frames
    // Bench rate, faster than line rate, keeps runs short
    assign tclk = rz ? neg : {NCH{t[1]}};
    assign tdat = rz ? pos : dp;
    assign tneg = dn;
endmodule

// >>> sim/test_tsm_top.sv
`timescale 1ns/10ps
`include "tsm_defs.vh"
module test_tsm_top;
    localparam NCH = 2;
    logic           clk;
    logic           rstn;
    logic [7:0]     avs_address;
    logic           avs_read;
    logic           avs_write;
    logic [31:0]    avs_writedata;
    wire  [31:0]    avs_readdata;
    wire            avs_waitrequest;
    wire            irq;
    wire            mclk;
    logic [3:0]     code;
    wire  [NCH-1:0] tclk;
    wire  [NCH-1:0] tdat;
    wire  [NCH-1:0] tneg;
    wire  [NCH-1:0] ind;
    wire  [NCH-1:0] oe;
    wire  [NCH-1:0] tip;
    wire  [NCH-1:0] ring;
    logic [NCH-1:0] src [7];
    logic           run;
    logic           rz;
    logic           mrun;
    logic [NCH-1:0] fpos;
    logic [NCH-1:0] fneg;
    logic [NCH-1:0] p;
    logic [NCH-1:0] n;
    logic [31:0]    seed;
    logic [31:0]    q;
    int             error_cnt;
    int             num_checks;

    tsm_framer #(.NCH(NCH)) tsm_framer_i
    (
        .run(run), .rz(rz), .mclk_run(mrun), .code(code), .pos(fpos), .neg(fneg),
        .mclk(mclk), .tclk(tclk), .tdat(tdat), .tneg(tneg)
    );
    tsm_top #(.NCH(NCH)) tsm_top_i
    (
        .clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .master_clock_in(mclk), .master_clock_freq_code(code),
        .tx_single_rail_data(tdat), .tx_system_clock(tclk),
        .tx_negative_rail_data((oe & ind) | (~oe & tneg)),
        .tx_indication_out(ind), .tx_indication_oe(oe),
        .pattern_generator_status(src[0]), .alarm_indication_detect(src[1]),
        .tx_overcurrent(src[2]), .tx_loss_of_signal(src[3]), .excess_zero_detect(src[4]),
        .bipolar_violation_detect(src[5]), .rx_loss_of_signal(src[6]),
        .line_out_tip(tip), .line_out_ring(ring), .tx_data_strobe(),
        .master_clock_missing(), .auto_reset()
    );

    initial
    begin
        clk = 0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [1:0] exp_ind(input int s);
        return s == 6 ? src[4] | src[5] : s == 7 ? src[6] : src[s];
    endfunction

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
        chk_reg({30'h0, got}, {30'h0, exp});
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Leading edge keeps two requests from touching the strobes in one step
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        q = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask

    task automatic cfg(input logic [2:0] sel, input logic es, inv, input logic [1:0] fmt);
        for (int c = 0; c < NCH; c++)
            bus(1, `TSM_REG_CHAN_BASE + 8'(4 * c), {24'h0, sel, es, inv, 1'b0, fmt});
    endtask

    task automatic frame();
        run <= 1;
        repeat (24) @(posedge clk);
        run <= 0;
        repeat (20) @(posedge clk);
    endtask

    initial
    begin
        #400000;
        error_cnt++;
        wrap_up();
    end

    initial
    begin
        rstn = 0;
        avs_address = 0;
        avs_read = 0;
        avs_write = 0;
        avs_writedata = 0;
        code = 0;
        run = 0;
        rz = 0;
        mrun = 1;
        fpos = 0;
        fneg = 0;
        seed = 77890;
        error_cnt = 0;
        num_checks = 0;
        for (int k = 0; k < 7; k++)
            src[k] = 0;
        repeat (6) @(posedge clk);
        rstn <= 1;
        repeat (40) @(posedge clk);
        bus(0, `TSM_REG_CHAN_BASE, 0);
        chk_reg(q, 0);
        bus(1, 8'hFC, 32'hFF);
        bus(0, 8'hFC, 0);
        chk_reg(q, 0);
        // Master clock follows the strap; the last code is out of range
        for (int c = 0; c < 5; c++)
        begin
            code <= 4'(c);
            repeat (60) @(posedge clk);
            bus(1, `TSM_REG_STATUS, 32'h7);
            repeat (60) @(posedge clk);
            bus(0, `TSM_REG_CLKSTAT, 0);
            chk_reg(q, {26'h0, c == 4, 1'b0, 4'(c)});
            bus(0, `TSM_REG_STATUS, 0);
            chk_reg(q & 32'h3, {30'h0, c == 4, 1'b0});
        end
        code <= 0;
        repeat (60) @(posedge clk);
        mrun <= 0;
        repeat (40) @(posedge clk);
        bus(0, `TSM_REG_CLKSTAT, 0);
        chk_reg(q, 32'h10);
        bus(1, `TSM_REG_MASK, 1);
        @(posedge clk);
        chk_reg({31'h0, irq}, 1);
        bus(1, `TSM_REG_MASK, 0);
        @(posedge clk);
        chk_reg({31'h0, irq}, 0);
        mrun <= 1;
        repeat (60) @(posedge clk);
        bus(0, `TSM_REG_STATUS, 0);
        chk_reg(q & 32'h1, 1);
        bus(1, `TSM_REG_STATUS, 32'h7);
        bus(1, `TSM_REG_MASK, 1);
        @(posedge clk);
        chk_reg({31'h0, irq}, 0);
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            fpos <= seed[1:0];
            fneg <= seed[3:2];
            cfg(0, i[0], i[1], `TSM_FMT_DR_NRZ);
            frame();
            chk_pin(oe, 0);
            chk_pin(tip, fpos ^ {2{i[0] ^ i[1]}});
            chk_pin(ring, fneg ^ {2{i[0] ^ i[1]}});
        end
        for (int s = 0; s < 8; s++)
        begin
            seed = lfsr(seed);
            for (int k = 0; k < 7; k++)
                src[k] <= seed[2*k +: 2];
            fpos <= seed[15:14];
            cfg(3'(s), seed[16], seed[17], `TSM_FMT_SR_NRZ);
            frame();
            chk_pin(oe, 2'h3);
            chk_pin(ind, exp_ind(s));
            chk_pin(tip, fpos ^ {2{seed[16] ^ seed[17]}});
        end
        bus(0, `TSM_REG_CHAN_BASE, 0);
        chk_reg(q & 32'h100, 32'h100);
        repeat (60) @(posedge clk);
        bus(0, `TSM_REG_STATUS, 0);
        chk_reg(q & 32'h4, 32'h4);
        bus(0, `TSM_REG_CHAN_BASE, 0);
        chk_reg(q & 32'h100, 0);
        rz <= 1;
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            fpos <= {seed[0], i[1]};
            fneg <= {seed[1], i[2]};
            cfg(seed[4:2], 0, i[0], `TSM_FMT_DR_RZ);
            repeat (8) @(posedge clk);
            p = fpos ^ {2{i[0]}};
            n = fneg ^ {2{i[0]}};
            chk_pin(tip, p & ~n);
            chk_pin(ring, n & ~p);
            chk_pin(ind, exp_ind(seed[4:2]));
        end
        wrap_up();
    end
endmodule
